// *** shared/pss_defs.svh ***
// constants for the program sequencer: offsets, field positions, reset values
`ifndef PSS_DEFS_SVH
`define PSS_DEFS_SVH

// ----------------------------------------
// widths and sizes
// ----------------------------------------
`define PSS_PC_W 13
`define PSS_WORD_W 16
`define PSS_STK_DEPTH 8
`define PSS_STK_FULL 4'h8
`define PSS_ONE 1'b1

// ----------------------------------------
// vectors and pages
// ----------------------------------------
`define PSS_RST_VEC 13'h0000
`define PSS_LAST_PAGE 5'h1F

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PSS_OFS_PCL 8'h00
`define PSS_OFS_TBLP 8'h01
`define PSS_OFS_TBHP 8'h02
`define PSS_OFS_TABLE_HIGH_LATCH 8'h03
`define PSS_OFS_STAT 8'h04
`define PSS_OFS_SEQ 8'h05

// ----------------------------------------
// status bit positions and reset values
// ----------------------------------------
`define PSS_ST_C 0
`define PSS_ST_AC 1
`define PSS_ST_Z 2
`define PSS_ST_OV 3
`define PSS_RST_STAT 4'h0
`define PSS_RST_BYTE 8'h00

// ----------------------------------------
// decimal adjust constants
// ----------------------------------------
`define PSS_BCD_MAX 4'h9
`define PSS_DAA_LO 8'h06
`define PSS_DAA_HI 8'h60

`endif

// *** shared/pss_pkg.sv ***
// types shared by the program sequencer
package pss_pkg;
`include "pss_defs.svh"

  // ----------------------------------------
  // phases and command encodings
  // ----------------------------------------
  typedef enum logic [3:0] {PSS_T1 = 4'b0001, PSS_T2 = 4'b0010, PSS_T3 = 4'b0100, PSS_T4 = 4'b1000} pss_phase_t;

  typedef enum logic [3:0] {PSS_K_NOP, PSS_K_ALU, PSS_K_JUMP, PSS_K_CALL, PSS_K_RET, PSS_K_RETURN_FROM_IRQ,
    PSS_K_SKIP, PSS_K_TABRD, PSS_K_TABRD_LAST} pss_kind_t;

  typedef enum logic [3:0] {PSS_A_ADD, PSS_A_ADC, PSS_A_SUB, PSS_A_SBC, PSS_A_DAA, PSS_A_AND, PSS_A_OR,
    PSS_A_XOR, PSS_A_CPL, PSS_A_RR, PSS_A_RRC, PSS_A_RL, PSS_A_RLC, PSS_A_INC, PSS_A_DEC, PSS_A_PASS} pss_alu_op_t;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    pss_kind_t kind;
    pss_alu_op_t alu_op;
    logic [7:0] opnd_a;
    logic [7:0] opnd_b;
    logic skip_if_zero;
    logic ext_sector;
    logic [`PSS_PC_W-1:0] target;
  } pss_cmd_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pss_reg_req_t;

  typedef struct packed {
    pss_phase_t phase;
    logic [`PSS_PC_W-1:0] pc;
    logic [2:0] sp;
    logic [3:0] depth;
    logic [`PSS_STK_DEPTH-1:0][`PSS_PC_W-1:0] stack;
    logic tbl_fetch;
    logic tbl_ext;
    logic tbl_last;
    logic pcl_pend;
    logic [7:0] pcl_val;
    logic irq_pend;
    logic [7:0] tblp;
    logic [4:0] tbhp;
    logic [7:0] table_high_latch;
    logic [3:0] status;
    logic [`PSS_PC_W-1:0] prog_addr;
    logic [`PSS_WORD_W-1:0] instr;
    logic instr_valid;
    logic [7:0] alu_res;
    logic alu_wr;
    logic [7:0] tbl_data;
    logic tbl_wr;
    logic tbl_ext_out;
    logic irq_ack;
    logic [7:0] rdata;
  } pss_state_t;

endpackage

// *** logic/pss_sequencer.sv ***
// program sequencer: phases, program counter, return stack, alu and table reads
`timescale 1ns/1ps
`include "pss_defs.svh"

// Function
// - pc advances by one per executed instruction
// - 13-bit pc, only low byte visible
// - low byte write jumps in page, dummy
// - taken skip discards prefetch, inserts dummy
// - jumps, calls, interrupts, reset load pc
// - branch or call takes two cycles
// - four phases form one instruction cycle
// - eight-level stack hidden from software
// - call or interrupt pushes, return pops
// - reset points stack pointer at top
// - full stack defers interrupt until return
// - call on full stack overwrites oldest
// - alu writes result and updates status
// - alu arithmetic, logic, rotate, skip tests
// - pc addresses 8K by 16 program memory
// - fetch starts at address zero after reset
// - table address from pointer low and high
// - table low byte out, high byte latched
// - normal and extended table read destinations
// - table reads take two instruction cycles
// - table high latch software readable, writable
module pss_sequencer (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire pss_pkg::pss_reg_req_t reg_req_in,
  input wire pss_pkg::pss_cmd_t cmd_in,
  input wire logic [15:0] prog_data_in,
  input wire logic irq_req_in,
  input wire logic [12:0] irq_vector_in,
  output pss_pkg::pss_phase_t phase_out,
  output logic [12:0] prog_addr_out,
  output logic [15:0] instr_out,
  output logic instr_valid_out,
  output logic [7:0] alu_result_out,
  output logic alu_wr_out,
  output logic [3:0] status_out,
  output logic [7:0] tbl_data_out,
  output logic tbl_wr_out,
  output logic tbl_ext_out,
  output logic irq_ack_out,
  output logic [7:0] rdata_out
);
  import pss_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  pss_state_t s;
  pss_state_t next_s;

  // alu working values
  logic [7:0] opa;
  logic [7:0] opb;
  logic ci;
  logic [8:0] sum;
  logic [4:0] lo;
  logic [7:0] adj;
  logic [7:0] res;
  logic [3:0] fl;

  // sequencing working values
  logic full;
  logic redirect;
  logic pcl_hit;
  logic pcl_take;
  logic [7:0] pcl_byte;
  logic plain_op;

  // ----------------------------------------
  // alu
  // ----------------------------------------
  // one combinational alu; the caller decides whether the result is kept
  always_comb
  begin
    opa = cmd_in.opnd_a;
    opb = cmd_in.opnd_b;
    ci = 1'b0;
    sum = 9'h000;
    lo = 5'h00;
    adj = `PSS_RST_BYTE;
    res = `PSS_RST_BYTE;
    fl = s.status;
    case (cmd_in.alu_op)
      PSS_A_ADC:
        ci = s.status[`PSS_ST_C];
      PSS_A_SUB:
      begin
        opb = ~cmd_in.opnd_b;
        ci = `PSS_ONE;
      end
      PSS_A_SBC:
      begin
        opb = ~cmd_in.opnd_b;
        ci = s.status[`PSS_ST_C];
      end
      default:
        ci = 1'b0;
    endcase
    // carry out of subtraction means no borrow, so one adder serves all four
    sum = {1'b0, opa} + {1'b0, opb} + {8'h00, ci};
    lo = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, ci};
    case (cmd_in.alu_op)
      PSS_A_ADD, PSS_A_ADC, PSS_A_SUB, PSS_A_SBC:
      begin
        res = sum[7:0];
        fl[`PSS_ST_C] = sum[8];
        fl[`PSS_ST_AC] = lo[4];
        fl[`PSS_ST_Z] = (sum[7:0] == `PSS_RST_BYTE);
        fl[`PSS_ST_OV] = (opa[7] == opb[7]) && (sum[7] != opa[7]);
      end
      PSS_A_DAA:
      begin
        if ((opa[3:0] > `PSS_BCD_MAX) || s.status[`PSS_ST_AC])
        begin
          adj = adj | `PSS_DAA_LO;
        end
        if ((opa[7:4] > `PSS_BCD_MAX) || s.status[`PSS_ST_C])
        begin
          adj = adj | `PSS_DAA_HI;
        end
        sum = {1'b0, opa} + {1'b0, adj};
        res = sum[7:0];
        fl[`PSS_ST_C] = sum[8] | s.status[`PSS_ST_C];
      end
      PSS_A_AND:
      begin
        res = opa & opb;
        fl[`PSS_ST_Z] = (res == `PSS_RST_BYTE);
      end
      PSS_A_OR:
      begin
        res = opa | opb;
        fl[`PSS_ST_Z] = (res == `PSS_RST_BYTE);
      end
      PSS_A_XOR:
      begin
        res = opa ^ opb;
        fl[`PSS_ST_Z] = (res == `PSS_RST_BYTE);
      end
      PSS_A_CPL:
      begin
        res = ~opa;
        fl[`PSS_ST_Z] = (res == `PSS_RST_BYTE);
      end
      PSS_A_RR:
        res = {opa[0], opa[7:1]};
      PSS_A_RRC:
      begin
        res = {s.status[`PSS_ST_C], opa[7:1]};
        fl[`PSS_ST_C] = opa[0];
      end
      PSS_A_RL:
        res = {opa[6:0], opa[7]};
      PSS_A_RLC:
      begin
        res = {opa[6:0], s.status[`PSS_ST_C]};
        fl[`PSS_ST_C] = opa[7];
      end
      PSS_A_INC:
      begin
        res = opa + 8'h01;
        fl[`PSS_ST_Z] = (res == `PSS_RST_BYTE);
      end
      PSS_A_DEC:
      begin
        res = opa - 8'h01;
        fl[`PSS_ST_Z] = (res == `PSS_RST_BYTE);
      end
      default:
        res = opa;
    endcase
  end

  // ----------------------------------------
  // sequencing and registers
  // ----------------------------------------
  // everything that changes the program flow happens on the edge closing phase four
  always_comb
  begin
    next_s = s;
    redirect = 1'b0;
    plain_op = 1'b0;
    full = (s.depth == `PSS_STK_FULL);
    pcl_hit = reg_req_in.wr && (reg_req_in.addr == `PSS_OFS_PCL);
    // a write landing on the very edge of phase four must not be missed
    pcl_take = s.pcl_pend || pcl_hit;
    pcl_byte = pcl_hit ? reg_req_in.wdata : s.pcl_val;
    next_s.alu_wr = 1'b0;
    next_s.tbl_wr = 1'b0;
    next_s.irq_ack = 1'b0;
    next_s.rdata = `PSS_RST_BYTE;

    case (s.phase)
      PSS_T1:
        next_s.phase = PSS_T2;
      PSS_T2:
        next_s.phase = PSS_T3;
      PSS_T3:
        next_s.phase = PSS_T4;
      PSS_T4:
        next_s.phase = PSS_T1;
      default:
        next_s.phase = PSS_T1;
    endcase

    // request is recorded even while acknowledge is held off
    // request flag recorded
    if (irq_req_in)
    begin
      next_s.irq_pend = 1'b1;
    end

    // register writes; the program counter byte waits for the cycle boundary
    if (reg_req_in.wr)
    begin
      if (reg_req_in.addr == `PSS_OFS_PCL)
      begin
        next_s.pcl_pend = 1'b1;
        next_s.pcl_val = reg_req_in.wdata;
      end
      else if (reg_req_in.addr == `PSS_OFS_TBLP)
      begin
        next_s.tblp = reg_req_in.wdata;
      end
      else if (reg_req_in.addr == `PSS_OFS_TBHP)
      begin
        next_s.tbhp = reg_req_in.wdata[4:0];
      end
      else if (reg_req_in.addr == `PSS_OFS_TABLE_HIGH_LATCH)
      begin
        next_s.table_high_latch = reg_req_in.wdata;
      end
      else if (reg_req_in.addr == `PSS_OFS_STAT)
      begin
        next_s.status = reg_req_in.wdata[3:0];
      end
    end

    // register reads; stack and its pointer have no address
    // stack not mapped
    if (reg_req_in.rd)
    begin
      if (reg_req_in.addr == `PSS_OFS_PCL)
      begin
        next_s.rdata = s.pc[7:0];
      end
      else if (reg_req_in.addr == `PSS_OFS_TBLP)
      begin
        next_s.rdata = s.tblp;
      end
      else if (reg_req_in.addr == `PSS_OFS_TBHP)
      begin
        next_s.rdata = {3'b000, s.tbhp};
      end
      else if (reg_req_in.addr == `PSS_OFS_TABLE_HIGH_LATCH)
      begin
        next_s.rdata = s.table_high_latch;
      end
      else if (reg_req_in.addr == `PSS_OFS_STAT)
      begin
        next_s.rdata = {4'h0, s.status};
      end
      else if (reg_req_in.addr == `PSS_OFS_SEQ)
      begin
        next_s.rdata = {3'b000, s.irq_pend, full, 3'b000};
      end
    end

    if (s.phase == PSS_T4)
    begin
      // fetch side: either the next instruction word or a table word
      if (s.tbl_fetch)
      begin
        // low byte out, high byte latched
        next_s.tbl_data = prog_data_in[7:0];
        next_s.table_high_latch = prog_data_in[15:8];
        next_s.tbl_wr = 1'b1;
        next_s.tbl_ext_out = s.tbl_ext;
        next_s.tbl_fetch = 1'b0;
        // the held instruction executes next; pc was not used for fetch
        next_s.instr_valid = 1'b1;
      end
      else
      begin
        next_s.instr = prog_data_in;
        next_s.instr_valid = 1'b1;
        next_s.pc = s.pc + 13'h0001;
      end

      // execute side; an invalid slot is a dummy cycle and ignores the decoder
      if (s.instr_valid)
      begin
        case (cmd_in.kind)
          PSS_K_ALU:
          begin
            next_s.alu_res = res;
            next_s.alu_wr = 1'b1;
            next_s.status = fl;
            plain_op = 1'b1;
          end
          PSS_K_SKIP:
          begin
            next_s.alu_res = res;
            next_s.alu_wr = 1'b1;
            if (cmd_in.skip_if_zero ? (res == `PSS_RST_BYTE) : (res != `PSS_RST_BYTE))
            begin
              redirect = 1'b1;
            end
          end
          PSS_K_JUMP:
          begin
            next_s.pc = cmd_in.target;
            redirect = 1'b1;
          end
          PSS_K_CALL:
          begin
            next_s.stack[s.sp] = s.pc;
            next_s.sp = s.sp + 3'd1;
            if (!full)
            begin
              next_s.depth = s.depth + 4'h1;
            end
            next_s.pc = cmd_in.target;
            redirect = 1'b1;
          end
          PSS_K_RET, PSS_K_RETURN_FROM_IRQ:
          begin
            next_s.sp = s.sp - 3'd1;
            next_s.pc = s.stack[s.sp - 3'd1];
            if (s.depth != 4'h0)
            begin
              next_s.depth = s.depth - 4'h1;
            end
            redirect = 1'b1;
          end
          PSS_K_TABRD, PSS_K_TABRD_LAST:
          begin
            // second cycle fetches the table word
            next_s.tbl_fetch = 1'b1;
            next_s.tbl_ext = cmd_in.ext_sector;
            next_s.tbl_last = (cmd_in.kind == PSS_K_TABRD_LAST);
          end
          default:
            plain_op = 1'b1;
        endcase

        // interrupt taken only at a plain instruction, never on a full stack
        // acknowledge after stack frees
        if (plain_op && s.irq_pend && !full && !pcl_take)
        begin
          next_s.stack[s.sp] = s.pc;
          next_s.sp = s.sp + 3'd1;
          next_s.depth = s.depth + 4'h1;
          next_s.pc = irq_vector_in;
          next_s.irq_pend = irq_req_in;
          next_s.irq_ack = 1'b1;
          redirect = 1'b1;
        end
        // in-page jump from low byte; a table read leaves the pc alone
        else if (pcl_take && !redirect && !next_s.tbl_fetch)
        begin
          next_s.pc = {s.pc[12:8], pcl_byte};
          redirect = 1'b1;
        end
      end

      // a pending byte is used or dropped at the boundary, never carried into a later cycle
      next_s.pcl_pend = 1'b0;

      if (redirect)
      begin
        next_s.instr_valid = 1'b0;
      end

      if (next_s.tbl_fetch)
      begin
        next_s.prog_addr = {next_s.tbl_last ? `PSS_LAST_PAGE : s.tbhp, s.tblp};
        next_s.instr_valid = 1'b0;
      end
      else
      begin
        next_s.prog_addr = next_s.pc;
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // synchronous reset; stack contents cleared only for tidiness
  always_ff @(posedge sys_clk_in)
  begin
    if (!resetn_in)
    begin
      s <= '0;
      s.phase <= PSS_T1;
      s.pc <= `PSS_RST_VEC;
      s.prog_addr <= `PSS_RST_VEC;
      s.sp <= 3'd0;
      s.depth <= 4'h0;
      s.status <= `PSS_RST_STAT;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // every output is a state field, so each one comes from a flip-flop
  assign phase_out = s.phase;
  assign prog_addr_out = s.prog_addr;
  assign instr_out = s.instr;
  assign instr_valid_out = s.instr_valid;
  assign alu_result_out = s.alu_res;
  assign alu_wr_out = s.alu_wr;
  assign status_out = s.status;
  assign tbl_data_out = s.tbl_data;
  assign tbl_wr_out = s.tbl_wr;
  assign tbl_ext_out = s.tbl_ext_out;
  assign irq_ack_out = s.irq_ack;
  assign rdata_out = s.rdata;

endmodule

// *** testbench/pss_prog_mem.sv ***
// program memory model on the far side of the fetch port
`timescale 1ns/1ps
module pss_prog_mem (
  input wire logic [12:0] addr_in,
  output logic [15:0] data_out
);
  // ----------------------------------------
  // word lookup
  // ----------------------------------------
  // whole 13-bit address
  // every address bit shows in the word, so any wrong fetch address is visible
  assign data_out = {3'h5, addr_in};
endmodule

// *** testbench/pss_properties.sv ***
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
module pss_properties (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire pss_pkg::pss_reg_req_t reg_req_in,
  input wire pss_pkg::pss_cmd_t cmd_in,
  input wire logic [12:0] irq_vector_in,
  input wire pss_pkg::pss_phase_t phase_out,
  input wire logic [12:0] prog_addr_out,
  input wire logic instr_valid_out,
  input wire logic alu_wr_out,
  input wire logic [3:0] status_out,
  input wire logic tbl_wr_out,
  input wire logic irq_ack_out,
  input wire logic [7:0] rdata_out
);
  import pss_pkg::*;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);
  property p_phase;
    1 |=> phase_out == (($past(phase_out) == PSS_T4) ? PSS_T1 : $past(phase_out) << 1);
  endproperty
  a_phase: assert property (p_phase) else $error("phase order broken");
  property p_vec;
    $rose(resetn_in) |-> prog_addr_out == 13'h0000 && !instr_valid_out && phase_out == PSS_T1;
  endproperty
  a_vec: assert property (p_vec) else $error("bad state after reset");
  property p_alu;
    alu_wr_out |-> $past(phase_out) == PSS_T4 && $past(instr_valid_out)
      && $past(cmd_in.kind) inside {PSS_K_ALU, PSS_K_SKIP};
  endproperty
  a_alu: assert property (p_alu) else $error("result pulse without command");
  property p_stat;
    $changed(status_out) |-> ($past(phase_out) == PSS_T4 && $past(instr_valid_out)
      && $past(cmd_in.kind) == PSS_K_ALU) || ($past(reg_req_in.wr) && $past(reg_req_in.addr) == 8'h04);
  endproperty
  a_stat: assert property (p_stat) else $error("status changed without cause");
  property p_tbl;
    tbl_wr_out |-> instr_valid_out && $past(phase_out) == PSS_T4 && !$past(instr_valid_out);
  endproperty
  a_tbl: assert property (p_tbl) else $error("table pulse misplaced");
  property p_ack;
    irq_ack_out |-> !instr_valid_out && prog_addr_out == $past(irq_vector_in) && $past(instr_valid_out)
      && $past(cmd_in.kind) inside {PSS_K_NOP, PSS_K_ALU};
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge without vector load");
  property p_br;
    phase_out == PSS_T4 && instr_valid_out && cmd_in.kind inside {PSS_K_JUMP, PSS_K_CALL}
      |=> prog_addr_out == $past(cmd_in.target) && !instr_valid_out ##4 instr_valid_out;
  endproperty
  a_br: assert property (p_br) else $error("branch timing wrong");
  property p_rd;
    reg_req_in.rd && reg_req_in.addr > 8'h05 |=> rdata_out == 8'h00;
  endproperty
  a_rd: assert property (p_rd) else $error("unmapped read not zero");
  // main scenarios reached
  c_ack: cover property (irq_ack_out);
  c_tbl: cover property (tbl_wr_out);
  c_alu: cover property (alu_wr_out);
endmodule
bind pss_sequencer pss_properties u_pss_properties (
  .sys_clk_in, .resetn_in, .reg_req_in, .cmd_in, .irq_vector_in, .phase_out, .prog_addr_out,
  .instr_valid_out, .alu_wr_out, .status_out, .tbl_wr_out, .irq_ack_out, .rdata_out
);

// *** testbench/test_program_sequencer_with_stack.sv ***
// self-checking bench for the program sequencer
`timescale 1ns/1ps
module test_program_sequencer_with_stack;
  import pss_pkg::*;
  logic sys_clk_in, resetn_in, irq_req_in, instr_valid_out, alu_wr_out, tbl_wr_out, tbl_ext_out, irq_ack_out;
  logic [12:0] irq_vector_in, prog_addr_out, a;
  logic [15:0] prog_data_in, instr_out;
  logic [7:0] alu_result_out, tbl_data_out, rdata_out;
  logic [3:0] status_out;
  pss_reg_req_t reg_req_in;
  pss_cmd_t cmd_in, nop, c;
  pss_phase_t phase_out;
  logic [12:0] pv [0:8];
  int fail_count, n_checks;
  // op, operand a, operand b, result, status after
  logic [31:0] alu_tab [0:15] = '{32'h0F02_0101, 32'h50FF_0005, 32'h6000_0005, 32'h75AF_FA51,
    32'hDFF0_0005, 32'hE010_0005, 32'h8550_0AA1, 32'hB810_0031, 32'h9010_0801, 32'hC800_0011,
    32'hA020_0810, 32'h41A0_0200, 32'h1010_1020, 32'h2050_5007, 32'h3050_4013, 32'hF3C0_03C3};
  // ----------------------------------------
  // design and program memory
  // ----------------------------------------
  pss_sequencer u_pss_sequencer (
    .sys_clk_in, .resetn_in, .reg_req_in, .cmd_in, .prog_data_in, .irq_req_in, .irq_vector_in,
    .phase_out, .prog_addr_out, .instr_out, .instr_valid_out, .alu_result_out, .alu_wr_out,
    .status_out, .tbl_data_out, .tbl_wr_out, .tbl_ext_out, .irq_ack_out, .rdata_out
  );
  pss_prog_mem u_pss_prog_mem (.addr_in(prog_addr_out), .data_out(prog_data_in));
  // 25 ns clock
  initial
  begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] w(input logic [12:0] ad);
    return {3'h5, ad};
  endfunction
  function automatic pss_cmd_t mk(input pss_kind_t k, input pss_alu_op_t o, input logic [7:0] x,
    input logic [7:0] y, input logic [12:0] t);
    return '{k, o, x, y, 1'b0, 1'b0, t};
  endfunction
  function automatic pss_cmd_t br(input pss_kind_t k, input logic [12:0] t);
    return mk(k, PSS_A_PASS, 8'h00, 8'h00, t);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge sys_clk_in) reg_req_in <= '{ad, d, 1'b1, 1'b0};
    @(posedge sys_clk_in) reg_req_in <= '0;
    #1;
  endtask
  task automatic reg_rd(input logic [7:0] ad, input logic [7:0] e);
    @(posedge sys_clk_in) reg_req_in <= '{ad, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk_in) reg_req_in <= '0;
    #1;
    chk(16'(rdata_out), 16'(e));
  endtask
  // one instruction cycle: command held from T2 until the edge closing T4
  task automatic cyc(input pss_cmd_t k);
    int i;
    i = 0;
    while (phase_out !== PSS_T1 && i < 8)
    begin
      i++;
      @(posedge sys_clk_in);
      #1;
    end
    if (i == 8)
    begin
      fail_count++;
      tally_and_finish();
    end
    @(posedge sys_clk_in) cmd_in <= k;
    repeat (3) @(posedge sys_clk_in);
    cmd_in <= nop;
    #1;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // reset state then straight fetch
  task automatic t_reset;
    @(posedge sys_clk_in) resetn_in <= 1'b0;
    repeat (20) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    #1;
    chk(16'(prog_addr_out), 16'h0000);
    repeat (3) cyc(nop);
    chk(16'(prog_addr_out), 16'h0003);
    chk(instr_out, w(13'h0002));
    reg_rd(8'h05, 8'h00);
  endtask
  task automatic t_alu;
    foreach (alu_tab[i])
    begin
      cyc(mk(PSS_K_ALU, pss_alu_op_t'(alu_tab[i][31:28]), alu_tab[i][27:20], alu_tab[i][19:12], 13'h0000));
      chk(16'(alu_wr_out), 16'h0001);
      chk(16'(alu_result_out), 16'(alu_tab[i][11:4]));
      chk(16'(status_out), 16'(alu_tab[i][3:0]));
    end
    reg_rd(8'h04, 8'h03);
  endtask
  task automatic t_skip;
    c = mk(PSS_K_SKIP, PSS_A_INC, 8'hFF, 8'h00, 13'h0000);
    c.skip_if_zero = 1'b1;
    cyc(nop);
    a = prog_addr_out;
    cyc(c);
    chk(16'(instr_valid_out), 16'h0000);
    cyc(nop);
    chk(instr_out, w(a + 13'h0001));
    c.opnd_a = 8'h01;
    cyc(c);
    chk(16'(instr_valid_out), 16'h0001);
    c.skip_if_zero = 1'b0;
    cyc(c);
    chk(16'(instr_valid_out), 16'h0000);
    chk(16'(alu_result_out), 16'h0002);
    cyc(nop);
  endtask
  // jump, then low byte write within page
  task automatic t_jump;
    cyc(br(PSS_K_JUMP, 13'h0ABC));
    chk(16'(prog_addr_out), 16'h0ABC);
    cyc(nop);
    chk(instr_out, w(13'h0ABC));
    reg_rd(8'h00, 8'hBD);
    a = 13'h0A40;
    reg_wr(8'h00, 8'h40);
    cyc(nop);
    chk(instr_out, w(a));
    chk(16'(prog_addr_out), 16'(a + 13'h0001));
  endtask
  task automatic t_table;
    reg_wr(8'h01, 8'h06);
    reg_wr(8'h02, 8'hFF);
    reg_rd(8'h02, 8'h1F);
    cyc(nop);
    a = prog_addr_out;
    cyc(br(PSS_K_TABRD, 13'h0000));
    chk(16'(prog_addr_out), 16'h1F06);
    cyc(nop);
    chk(16'(tbl_wr_out), 16'h0001);
    chk(16'(tbl_data_out), 16'h0006);
    chk(16'(tbl_ext_out), 16'h0000);
    chk(16'(prog_addr_out), 16'(a + 13'h0001));
    chk(instr_out, w(a));
    reg_rd(8'h03, 8'hBF);
    reg_wr(8'h02, 8'h02);
    reg_wr(8'h01, 8'h07);
    c = br(PSS_K_TABRD_LAST, 13'h0000);
    c.ext_sector = 1'b1;
    cyc(c);
    chk(16'(prog_addr_out), 16'h1F07);
    cyc(nop);
    chk(16'(tbl_ext_out), 16'h0001);
    cyc(br(PSS_K_TABRD, 13'h0000));
    chk(16'(prog_addr_out), 16'h0207);
    cyc(nop);
    chk(16'(tbl_data_out), 16'h0007);
    reg_wr(8'h03, 8'h5A);
    reg_rd(8'h03, 8'h5A);
    reg_wr(8'h33, 8'hFF);
    reg_rd(8'h33, 8'h00);
  endtask
  task automatic t_stack;
    cyc(nop);
    for (int i = 0; i < 9; i++)
    begin
      pv[i] = prog_addr_out;
      cyc(br(PSS_K_CALL, 13'h0200 + 13'(i * 16)));
      cyc(nop);
    end
    reg_rd(8'h05, 8'h08);
    @(posedge sys_clk_in) irq_req_in <= 1'b1;
    @(posedge sys_clk_in) irq_req_in <= 1'b0;
    cyc(nop);
    chk(16'(irq_ack_out), 16'h0000);
    reg_rd(8'h05, 8'h18);
    cyc(br(PSS_K_RET, 13'h0000));
    chk(16'(prog_addr_out), 16'(pv[8]));
    cyc(nop);
    cyc(nop);
    chk(16'(irq_ack_out), 16'h0001);
    chk(16'(prog_addr_out), 16'(irq_vector_in));
    cyc(nop);
    cyc(br(PSS_K_RETURN_FROM_IRQ, 13'h0000));
    chk(16'(prog_addr_out), 16'(pv[8] + 13'h0001));
    for (int i = 7; i > 0; i--)
    begin
      cyc(nop);
      cyc(br(PSS_K_RET, 13'h0000));
      chk(16'(prog_addr_out), 16'(pv[i]));
    end
    cyc(nop);
    cyc(br(PSS_K_RET, 13'h0000));
    chk(16'(prog_addr_out), 16'(pv[8] + 13'h0001));
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    resetn_in = 1'b0;
    irq_req_in = 1'b0;
    irq_vector_in = 13'h0040;
    reg_req_in = '0;
    nop = '0;
    cmd_in = '0;
    fail_count = 0;
    n_checks = 0;
    t_reset();
    t_alu();
    t_skip();
    t_jump();
    t_table();
    t_stack();
    t_reset();
    tally_and_finish();
  end
endmodule
